// ==== hw/wdt_map.svh ====
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH

// Register indices; byte address is four times the index
`define WDT_IDX_CONTROL 16'hFFAE
`define WDT_IDX_COUNTER 16'hFFB0
`define WDT_IDX_IRQ_STATUS 16'hFFB2
`define WDT_IDX_IRQ_MASK 16'hFFB4
`define WDT_IDX_STATE 16'hFFB6
`define WDT_ADDR_W 18

// Control register fields
`define WDT_RELOAD_MSB 15
`define WDT_RELOAD_LSB 8
`define WDT_FLAGS_MSB 5
`define WDT_FLAGS_LSB 1
`define WDT_PRESCALE_BIT 0
`define WDT_RELOAD_RST 8'h00
`define WDT_PRESCALE_RST 1'b0

// Flag vector bits (control bits 5..1)
`define WDT_F_POWER_ON 4
`define WDT_F_LONG_HW 3
`define WDT_F_SHORT_HW 2
`define WDT_F_SOFTWARE 1
`define WDT_F_WATCHDOG 0
`define WDT_FLAGS_POR 5'h1E

// Interrupt status bits
`define WDT_IRQ_OVERFLOW 0
`define WDT_IRQ_PIN_RESET 1
`define WDT_IRQ_DISABLE_REFUSED 2
`define WDT_IRQ_BITS 3

// Prescaler ratios
`define WDT_DIV_SLOW 128
`define WDT_DIV_FAST 2

// Timing: TCL is half a CPU clock period
`define WDT_CLK_NS 40
`define WDT_TCL_NS 20
`define WDT_LONG_TCL 1040
`define WDT_SHORT_TCL 4
`define WDT_HOLD_TCL 1024
`define WDT_LONG_CYC ((`WDT_LONG_TCL * `WDT_TCL_NS) / `WDT_CLK_NS)
`define WDT_SHORT_CYC ((`WDT_SHORT_TCL * `WDT_TCL_NS) / `WDT_CLK_NS)
`define WDT_HOLD_CYC ((`WDT_HOLD_TCL * `WDT_TCL_NS + `WDT_CLK_NS - 1) / `WDT_CLK_NS)

`endif

// ==== hw/wdt_pkg.sv ====
`default_nettype none

package wdt_pkg;

    typedef enum logic [0:0] {
        ST_RUN,
        ST_HOLD
    } reset_state_t;

    typedef logic [4:0] reset_flags_t;

endpackage : wdt_pkg

`default_nettype wire

// ==== hw/wdt_prescaler.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "wdt_map.svh"

module wdt_prescaler #(
    parameter int CNT_W = 7
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_clear,
    input wire logic i_slow,
    output logic o_tick
);

    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] last;

    if ((1 << CNT_W) < `WDT_DIV_SLOW) begin : g_bad_cnt_w
        $error("prescaler counter too narrow");
    end

    assign last = i_slow ? CNT_W'(`WDT_DIV_SLOW - 1) : CNT_W'(`WDT_DIV_FAST - 1);

    // Divide by 2 or 128 depending on the select bit
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt <= '0;
        end else if (i_clear || cnt >= last) begin
            cnt <= '0;
        end else begin
            cnt <= cnt + CNT_W'(1);
        end
    end

    assign o_tick = !i_clear && (cnt >= last);

endmodule : wdt_prescaler

`default_nettype wire

// ==== hw/watchdog_reset_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "wdt_map.svh"

module watchdog_reset_monitor #(
    parameter int CNT_W = 16,
    parameter int HOLD_CYCLES = `WDT_HOLD_CYC
) (
    input wire logic I_CLK,
    input wire logic I_RESETN,
    input wire logic [`WDT_ADDR_W-1:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [31:0] I_AVS_WRITEDATA,
    input wire logic [3:0] I_AVS_BYTEENABLE,
    output logic [31:0] O_AVS_READDATA,
    output logic O_AVS_WAITREQUEST,
    input wire logic I_SERVICE_INSTR,
    input wire logic I_END_OF_INIT_INSTR,
    input wire logic I_SOFT_RESET_INSTR,
    input wire logic I_DISABLE_INSTR,
    input wire logic I_RESET_IN_PIN_N,
    input wire logic I_POWER_ON_DETECT,
    output logic O_RESET_OUT_PIN_N,
    output logic O_CHIP_RESET,
    output logic O_IRQ
);

    if (CNT_W != 16) begin : g_bad_cnt_w
        $error("watchdog counter must be 16 bits");
    end
    if (HOLD_CYCLES < 1 || HOLD_CYCLES > 65535) begin : g_bad_hold
        $error("HOLD_CYCLES out of range");
    end

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    wdt_pkg::reset_state_t state;
    wdt_pkg::reset_flags_t flags, flag_set, flag_clr;
    logic [7:0] reload_value;
    logic prescale_select;
    logic [CNT_W-1:0] counter;
    logic enabled;
    logic init_done;
    logic tick, overflow;
    logic [15:0] hold_cnt;
    logic [9:0] low_cnt;
    logic pin_s1, pin_s2, pin_s3;
    logic pin_level;
    logic pin_low_seen;
    logic pin_release, pin_is_long, pin_is_short;
    logic power_on_s1, power_on_s2, power_on_s3;
    logic power_on_level;
    logic hold_done;
    logic enter_hold;
    logic in_hold;
    logic ack, req, wr_en;
    logic disable_refused;
    logic [`WDT_IRQ_BITS-1:0] irq_status;
    logic [`WDT_IRQ_BITS-1:0] irq_mask;
    logic [`WDT_IRQ_BITS-1:0] irq_event;
    logic [31:0] next_readdata;

    function automatic logic addr_hit(input logic [`WDT_ADDR_W-1:0] addr,
                                      input logic [15:0] idx);
        addr_hit = (addr == {idx, 2'b00});
    endfunction : addr_hit

    // ------------------------------------------------------------
    // Avalon slave handshake: one wait cycle per access
    // ------------------------------------------------------------
    assign req = I_AVS_READ || I_AVS_WRITE;
    assign O_AVS_WAITREQUEST = req && !ack;
    assign wr_en = I_AVS_WRITE && ack;

    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            ack <= 1'b0;
        end else begin
            ack <= req && !ack;
        end
    end

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            pin_s1 <= 1'b1;
            pin_s2 <= 1'b1;
            pin_s3 <= 1'b1;
            pin_level <= 1'b1;
            power_on_s1 <= 1'b0;
            power_on_s2 <= 1'b0;
            power_on_s3 <= 1'b0;
            power_on_level <= 1'b0;
        end else begin
            pin_s1 <= I_RESET_IN_PIN_N;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            if (pin_s2 == pin_s3) begin
                pin_level <= pin_s3;
            end
            power_on_s1 <= I_POWER_ON_DETECT;
            power_on_s2 <= power_on_s1;
            power_on_s3 <= power_on_s2;
            if (power_on_s2 == power_on_s3) begin
                power_on_level <= power_on_s3;
            end
        end
    end

    // ------------------------------------------------------------
    // Reset input pulse measurement
    // ------------------------------------------------------------
    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            low_cnt <= '0;
            pin_low_seen <= 1'b0;
        end else if (!pin_level) begin
            pin_low_seen <= 1'b1;
            if (low_cnt != '1) begin
                low_cnt <= low_cnt + 10'h001;
            end
        end else begin
            pin_low_seen <= 1'b0;
            low_cnt <= '0;
        end
    end

    assign pin_release = pin_level && pin_low_seen;
    assign pin_is_long = low_cnt > 10'(`WDT_LONG_CYC);
    assign pin_is_short = low_cnt >= 10'(`WDT_SHORT_CYC);

    // ------------------------------------------------------------
    // Internal reset sequencer
    // ------------------------------------------------------------
    assign enter_hold = overflow || I_SOFT_RESET_INSTR
        || (!pin_level && low_cnt >= 10'(`WDT_SHORT_CYC));
    assign hold_done = (hold_cnt >= 16'(HOLD_CYCLES - 1)) && pin_level;
    assign in_hold = (state == wdt_pkg::ST_HOLD);

    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            state <= wdt_pkg::ST_RUN;
            hold_cnt <= '0;
        end else begin
            case (state)
                wdt_pkg::ST_RUN: begin
                    hold_cnt <= '0;
                    if (enter_hold) begin
                        state <= wdt_pkg::ST_HOLD;
                    end
                end
                wdt_pkg::ST_HOLD: begin
                    if (hold_cnt != '1) begin
                        hold_cnt <= hold_cnt + 16'h0001;
                    end
                    if (hold_done) begin
                        state <= wdt_pkg::ST_RUN;
                    end
                end
                default: begin
                    state <= wdt_pkg::ST_RUN;
                end
            endcase
        end
    end

    assign O_CHIP_RESET = in_hold;
    assign O_RESET_OUT_PIN_N = !in_hold;

    // ------------------------------------------------------------
    // Enable and initialisation phase
    // ------------------------------------------------------------
    assign disable_refused = I_DISABLE_INSTR && init_done;

    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            enabled <= 1'b1;
            init_done <= 1'b0;
        end else if (in_hold) begin
            enabled <= 1'b1;
            init_done <= 1'b0;
        end else begin
            if (I_DISABLE_INSTR && !init_done) begin
                enabled <= 1'b0;
            end
            if (I_END_OF_INIT_INSTR) begin
                init_done <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Control register: reload and prescale select
    // ------------------------------------------------------------
    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            reload_value <= `WDT_RELOAD_RST;
            prescale_select <= `WDT_PRESCALE_RST;
        end else if (in_hold) begin
            reload_value <= `WDT_RELOAD_RST;
            prescale_select <= `WDT_PRESCALE_RST;
        end else if (wr_en && addr_hit(I_AVS_ADDRESS, `WDT_IDX_CONTROL)) begin
            if (I_AVS_BYTEENABLE[1]) begin
                reload_value <= I_AVS_WRITEDATA[`WDT_RELOAD_MSB:`WDT_RELOAD_LSB];
            end
            if (I_AVS_BYTEENABLE[0]) begin
                prescale_select <= I_AVS_WRITEDATA[`WDT_PRESCALE_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // Watchdog counter
    // ------------------------------------------------------------
    wdt_prescaler #(
        .CNT_W(7)
    ) u_prescaler (
        .i_clk(I_CLK),
        .i_resetn(I_RESETN),
        .i_clear(in_hold || I_SERVICE_INSTR || !enabled),
        .i_slow(prescale_select),
        .o_tick(tick)
    );

    assign overflow = !in_hold && enabled && tick && (counter == '1);

    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            counter <= '0;
        end else if (in_hold) begin
            counter <= {`WDT_RELOAD_RST, 8'h00};
        end else if (I_SERVICE_INSTR) begin
            counter <= {reload_value, 8'h00};
        end else if (overflow) begin
            counter <= {reload_value, 8'h00};
        end else if (enabled && tick) begin
            counter <= counter + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // Reset indication flags; set wins over clear
    // ------------------------------------------------------------
    always_comb begin
        flag_set = '0;
        flag_clr = '0;
        if (overflow) begin
            flag_set[`WDT_F_WATCHDOG] = 1'b1;
            flag_set[`WDT_F_SOFTWARE] = 1'b1;
        end
        if (state == wdt_pkg::ST_RUN && I_SOFT_RESET_INSTR) begin
            flag_set[`WDT_F_SOFTWARE] = 1'b1;
        end
        if (pin_release && pin_is_short) begin
            flag_set[`WDT_F_SHORT_HW] = 1'b1;
            flag_set[`WDT_F_SOFTWARE] = 1'b1;
            flag_clr[`WDT_F_WATCHDOG] = 1'b1;
            if (pin_is_long) begin
                flag_set[`WDT_F_LONG_HW] = 1'b1;
                flag_set[`WDT_F_POWER_ON] = power_on_level;
            end
        end
        if (I_SERVICE_INSTR) begin
            flag_clr[`WDT_F_WATCHDOG] = 1'b1;
        end
        if (I_END_OF_INIT_INSTR && !in_hold) begin
            flag_clr = '1;
        end
    end

    // Bus writes never reach the flags
    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            flags <= `WDT_FLAGS_POR;
        end else begin
            flags <= (flags & ~flag_clr) | flag_set;
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    assign irq_event[`WDT_IRQ_OVERFLOW] = overflow;
    assign irq_event[`WDT_IRQ_PIN_RESET] = pin_release && pin_is_short;
    assign irq_event[`WDT_IRQ_DISABLE_REFUSED] = disable_refused;

    genvar gi;
    generate
        for (gi = 0; gi < `WDT_IRQ_BITS; gi++) begin : g_irq
            always_ff @(posedge I_CLK or negedge I_RESETN) begin
                if (!I_RESETN) begin
                    irq_status[gi] <= 1'b0;
                end else if (irq_event[gi]) begin
                    irq_status[gi] <= 1'b1;
                end else if (wr_en && I_AVS_BYTEENABLE[0]
                        && addr_hit(I_AVS_ADDRESS, `WDT_IDX_IRQ_STATUS)
                        && I_AVS_WRITEDATA[gi]) begin
                    irq_status[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            irq_mask <= '0;
        end else if (wr_en && I_AVS_BYTEENABLE[0]
                && addr_hit(I_AVS_ADDRESS, `WDT_IDX_IRQ_MASK)) begin
            irq_mask <= I_AVS_WRITEDATA[`WDT_IRQ_BITS-1:0];
        end
    end

    assign O_IRQ = |(irq_status & irq_mask);

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_comb begin
        next_readdata = '0;
        if (addr_hit(I_AVS_ADDRESS, `WDT_IDX_CONTROL)) begin
            next_readdata[`WDT_RELOAD_MSB:`WDT_RELOAD_LSB] = reload_value;
            next_readdata[`WDT_FLAGS_MSB:`WDT_FLAGS_LSB] = flags;
            next_readdata[`WDT_PRESCALE_BIT] = prescale_select;
        end else if (addr_hit(I_AVS_ADDRESS, `WDT_IDX_COUNTER)) begin
            next_readdata[CNT_W-1:0] = counter;
        end else if (addr_hit(I_AVS_ADDRESS, `WDT_IDX_IRQ_STATUS)) begin
            next_readdata[`WDT_IRQ_BITS-1:0] = irq_status;
        end else if (addr_hit(I_AVS_ADDRESS, `WDT_IDX_IRQ_MASK)) begin
            next_readdata[`WDT_IRQ_BITS-1:0] = irq_mask;
        end else if (addr_hit(I_AVS_ADDRESS, `WDT_IDX_STATE)) begin
            next_readdata[2:0] = {in_hold, init_done, enabled};
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            O_AVS_READDATA <= '0;
        end else if (I_AVS_READ && !ack) begin
            O_AVS_READDATA <= next_readdata;
        end
    end

endmodule : watchdog_reset_monitor

`default_nettype wire

// ==== bench/watchdog_reset_monitor_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "wdt_map.svh"

module watchdog_reset_monitor_checker #(
    parameter int HOLD_CYCLES = 8
) (
    input wire logic I_CLK,
    input wire logic I_RESETN,
    input wire logic [`WDT_ADDR_W-1:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [31:0] I_AVS_WRITEDATA,
    input wire logic [3:0] I_AVS_BYTEENABLE,
    input wire logic [31:0] O_AVS_READDATA,
    input wire logic O_AVS_WAITREQUEST,
    input wire logic I_SOFT_RESET_INSTR,
    input wire logic I_RESET_IN_PIN_N,
    input wire logic O_RESET_OUT_PIN_N,
    input wire logic O_CHIP_RESET,
    input wire logic O_IRQ
);
    // ----------------------------------------
    // Length of the current internal reset
    // ----------------------------------------
    logic [15:0] hold_cnt;
    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            hold_cnt <= 16'h0000;
        end else if (O_CHIP_RESET) begin
            hold_cnt <= hold_cnt + 16'h0001;
        end else begin
            hold_cnt <= 16'h0000;
        end
    end

    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RESETN);

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    sequence s_req_start;
        $rose(I_AVS_READ | I_AVS_WRITE);
    endsequence
    sequence s_one_wait;
        O_AVS_WAITREQUEST ##1 !O_AVS_WAITREQUEST;
    endsequence

    AST_ONE_WAIT: assert property (s_req_start |-> s_one_wait)
        else $error("bus answer not after one wait cycle");
    AST_PIN_CHIP: assert property (
        O_CHIP_RESET == !O_RESET_OUT_PIN_N)
        else $error("reset output and chip reset disagree");
    AST_HOLD_MIN: assert property (
        $fell(O_CHIP_RESET) |-> hold_cnt >= HOLD_CYCLES)
        else $error("internal reset shorter than hold length");
    AST_PIN_HOLD: assert property (
        !I_RESET_IN_PIN_N [*8] |-> O_CHIP_RESET)
        else $error("low reset pin did not reset chip");
    AST_SOFT: assert property (
        I_SOFT_RESET_INSTR |=> O_CHIP_RESET)
        else $error("soft reset instruction ignored");
    AST_UNMAPPED: assert property (I_AVS_READ && !O_AVS_WAITREQUEST
        && I_AVS_ADDRESS == 18'h00000 |-> O_AVS_READDATA == 32'h00000000)
        else $error("unmapped read not zero");
    AST_IRQ_CLEAR: assert property (I_AVS_WRITE && !O_AVS_WAITREQUEST
        && I_AVS_ADDRESS == {`WDT_IDX_IRQ_STATUS, 2'b00}
        && I_AVS_WRITEDATA[2:0] == 3'h7 && I_AVS_BYTEENABLE[0] |=> !O_IRQ)
        else $error("irq still high after status clear");
    AST_OUT_AFTER_RESET: assert property (
        $rose(I_RESETN) |-> O_RESET_OUT_PIN_N && !O_IRQ)
        else $error("bad outputs after reset release");
endmodule : watchdog_reset_monitor_checker

bind watchdog_reset_monitor watchdog_reset_monitor_checker #(
    .HOLD_CYCLES(HOLD_CYCLES)
) u_chk (
    .I_CLK(I_CLK), .I_RESETN(I_RESETN), .I_AVS_ADDRESS(I_AVS_ADDRESS),
    .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE),
    .I_AVS_WRITEDATA(I_AVS_WRITEDATA), .I_AVS_BYTEENABLE(I_AVS_BYTEENABLE),
    .O_AVS_READDATA(O_AVS_READDATA), .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST),
    .I_SOFT_RESET_INSTR(I_SOFT_RESET_INSTR),
    .I_RESET_IN_PIN_N(I_RESET_IN_PIN_N),
    .O_RESET_OUT_PIN_N(O_RESET_OUT_PIN_N), .O_CHIP_RESET(O_CHIP_RESET),
    .O_IRQ(O_IRQ)
);
`default_nettype wire

// ==== bench/watchdog_reset_monitor_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "wdt_map.svh"

module watchdog_reset_monitor_tb;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [17:0] adr = 18'h00000;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h00000000;
    logic [3:0] ins = 4'h0;
    logic pin_n = 1'b1;
    logic pod = 1'b0;
    logic [3:0] be = 4'hF;
    logic [31:0] rdat;
    logic [31:0] q;
    logic wreq;
    logic rst_n;
    logic chip;
    logic irq;
    int bad_count = 0;
    int n_tests = 0;

    always #20 clk = ~clk;

    watchdog_reset_monitor #(.HOLD_CYCLES(8)) u_dut (
        .I_CLK(clk), .I_RESETN(resetn), .I_AVS_ADDRESS(adr),
        .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wd),
        .I_AVS_BYTEENABLE(be), .O_AVS_READDATA(rdat),
        .O_AVS_WAITREQUEST(wreq), .I_SERVICE_INSTR(ins[0]),
        .I_END_OF_INIT_INSTR(ins[1]), .I_SOFT_RESET_INSTR(ins[2]),
        .I_DISABLE_INSTR(ins[3]), .I_RESET_IN_PIN_N(pin_n),
        .I_POWER_ON_DETECT(pod), .O_RESET_OUT_PIN_N(rst_n),
        .O_CHIP_RESET(chip), .O_IRQ(irq)
    );

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task complete_run;
        if (bad_count == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : complete_run

    task check(input string nm, input logic [31:0] seen,
               input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
            bad_count++;
        end
    endtask : check

    task bus(input logic w, input logic [15:0] idx, input logic [31:0] d);
        int i;
        adr <= {idx, 2'b00};
        rd <= !w;
        wr <= w;
        wd <= d;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (wreq === 1'b0) break;
        end
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        if (i == 50) begin
            bad_count++;
            complete_run();
        end
        @(posedge clk);
    endtask : bus

    task rdchk(input string nm, input logic [15:0] idx,
               input logic [31:0] exp);
        bus(1'b0, idx, 32'h00000000);
        check(nm, q, exp);
    endtask : rdchk

    // Bit 0 service, 1 end of init, 2 soft reset, 3 disable
    task pulse(input logic [3:0] m);
        ins <= m;
        @(posedge clk);
        ins <= 4'h0;
        @(posedge clk);
    endtask : pulse

    task wait_run;
        int i;
        for (i = 0; i < 3000 && chip !== 1'b0; i++) @(posedge clk);
        if (i == 3000) begin
            bad_count++;
            complete_run();
        end
    endtask : wait_run

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_reset;
        rdchk("ctl_rst", `WDT_IDX_CONTROL, 32'h0000003C);
        rdchk("state_rst", `WDT_IDX_STATE, 32'h00000001);
        check("out_rst", 32'(rst_n), 32'h00000001);
    endtask : t_reset

    task t_regs;
        bus(1'b1, `WDT_IDX_CONTROL, 32'h0000FFFF);
        rdchk("ctl_rw", `WDT_IDX_CONTROL,
              32'h0000FF3D);
        be <= 4'h1;
        bus(1'b1, `WDT_IDX_CONTROL, 32'h00000000);
        be <= 4'hF;
        rdchk("ctl_lane", `WDT_IDX_CONTROL, 32'h0000FF3C);
        bus(1'b1, 16'h0000, 32'hFFFFFFFF);
        rdchk("unmapped", 16'h0000, 32'h00000000);
    endtask : t_regs

    task t_init;
        logic a;
        pulse(4'h2);
        rdchk("ctl_eoi", `WDT_IDX_CONTROL,
              32'h0000FF00);
        pulse(4'h8);
        rdchk("state_lock", `WDT_IDX_STATE, 32'h00000003);
        rdchk("irq_refused", `WDT_IDX_IRQ_STATUS, 32'h00000004);
        bus(1'b1, `WDT_IDX_IRQ_MASK, 32'h00000007);
        a = irq;
        bus(1'b1, `WDT_IDX_IRQ_MASK, 32'h00000000);
        check("irq_mask", 32'(a ^ irq), 32'h00000001);
        bus(1'b1, `WDT_IDX_IRQ_MASK, 32'h00000007);
        bus(1'b1, `WDT_IDX_IRQ_STATUS, 32'h00000007);
        rdchk("irq_clr", `WDT_IDX_IRQ_STATUS, 32'h00000000);
        check("irq_low", 32'(irq), 32'h00000000);
    endtask : t_init

    task t_timeout(input logic [31:0] ctl, input int exp);
        int n;
        bus(1'b1, `WDT_IDX_CONTROL, ctl);
        pulse(4'h1);
        for (n = 0; n < exp + 9 && chip !== 1'b1; n++) @(posedge clk);
        check("timeout", 32'(n >= exp - 2 && n <= exp + 3),
              32'h1);
        check("reset_out", 32'(rst_n), 32'h00000000);
        wait_run();
        rdchk("flags_wdt", `WDT_IDX_CONTROL,
              32'h00000006);
        rdchk("irq_wdt", `WDT_IDX_IRQ_STATUS, 32'h00000001);
        check("irq_high", 32'(irq), 32'h00000001);
    endtask : t_timeout

    task t_disable;
        logic [31:0] c;
        bus(1'b1, `WDT_IDX_CONTROL, 32'h0000FF00);
        pulse(4'h1);
        rdchk("wdt_clr", `WDT_IDX_CONTROL, 32'h0000FF04);
        pulse(4'h8);
        rdchk("state_dis", `WDT_IDX_STATE, 32'h00000000);
        bus(1'b0, `WDT_IDX_COUNTER, 32'h00000000);
        c = q;
        check("cnt_hi", 32'(c[15:8]), 32'h000000FF);
        repeat (700) @(posedge clk);
        rdchk("cnt_stop", `WDT_IDX_COUNTER, c);
        check("no_reset", 32'(chip), 32'h00000000);
        pulse(4'h4);
        wait_run();
        rdchk("state_soft", `WDT_IDX_STATE, 32'h00000001);
        rdchk("ctl_soft", `WDT_IDX_CONTROL, 32'h00000004);
    endtask : t_disable

    task t_pin(input int len, input logic p, input logic [31:0] exp);
        bus(1'b1, `WDT_IDX_IRQ_STATUS, 32'h00000007);
        pulse(4'h2);
        pod <= p;
        pin_n <= 1'b0;
        repeat (len) @(posedge clk);
        pin_n <= 1'b1;
        wait_run();
        rdchk("ctl_pin", `WDT_IDX_CONTROL,
              exp);
        rdchk("irq_pin", `WDT_IDX_IRQ_STATUS, 32'h00000002);
        pod <= 1'b0;
    endtask : t_pin

    initial begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        t_reset();
        t_regs();
        t_init();
        t_timeout(32'h0000FF00, 512);
        t_timeout(32'h0000FF01, 32768);
        t_disable();
        t_pin(20, 1'b0, 32'h0000000C);
        t_pin(600, 1'b1, 32'h0000003C);
        complete_run();
    end
endmodule : watchdog_reset_monitor_tb
`default_nettype wire
